// [dcwsm_bus_master.sv]
`timescale 1ns/100ps
module dcwsm_bus_master (
  // Clock
  input wire logic clk_i,
  // Register port
  output logic [7:0] addr_o,
  output logic [15:0] wr_data_o,
  output logic wr_o,
  output logic rd_o,
  input wire logic [15:0] rd_data_i
);
  // Command patterns the controller sends
  localparam logic [15:0] CW_SHUTDOWN = 16'h0006;
  localparam logic [15:0] CW_ENABLE = 16'h000F;
  localparam logic [15:0] CW_SWITCH_ON = 16'h0007;
  localparam logic [15:0] CW_DIS_VOLT = 16'h0000;
  localparam logic [15:0] CW_QSTOP = 16'h0002;

  initial begin
    addr_o = 8'h00;
    wr_data_o = 16'h0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // Idle lines show the inverse so a stale value is never mistaken for live data
  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wr_data_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wr_data_o <= ~d;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rd_data_i;
  endtask : read_reg

  // State learnt by masking the status word
  task automatic read_state(output logic [3:0] s);
    logic [15:0] d;
    read_reg(dcwsm_pkg::ADDR_STATUS, d);
    s = d[3:0];
  endtask : read_state
endmodule : dcwsm_bus_master

// [dcwsm_pkg.sv]
package dcwsm_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h04;
  localparam logic [7:0] ADDR_ASSIGN = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  // Command word bit positions
  localparam int B_SWITCH_ON = 0;
  localparam int B_EN_VOLT = 1;
  localparam int B_QSTOP = 2;
  localparam int B_EN_OP = 3;
  localparam int B_FRESET = 7;
  localparam int B_HALT = 8;
  localparam int B_ASSIGN_BASE = 10;
  // Configuration register fields
  localparam int CFG_STOP_KIND = 0;
  localparam int CFG_DIS_OP_STOP = 2;
  localparam int CFG_QS_HOLD = 3;
  localparam int CFG_ERR_POWER = 4;
  localparam int CFG_ERR_STAGE = 5;
  localparam int CFG_W = 6;
  localparam logic [5:0] CFG_RST = 6'h00;
  // Function assignment fields, one 3-bit code each
  localparam int ASG_REVERSE = 0;
  localparam int ASG_FAST = 4;
  localparam int ASG_FREEWHEEL = 8;
  localparam int ASG_DC = 12;
  localparam logic [2:0] ASG_NONE = 3'h0;
  localparam logic [2:0] ASG_C311 = 3'h1;
  localparam logic [2:0] ASG_C315 = 3'h5;
  localparam logic [15:0] ASSIGN_RST = 16'h0001;
  localparam logic [15:0] CMD_RST = 16'h0000;
  // Status register fields
  localparam int ST_REFUSED = 4;
  localparam int ST_MOTOR = 5;
  localparam int ST_STAGE = 6;
  localparam int ST_HALT = 7;

  typedef enum logic [3:0] {
    ST_NOT_READY = 4'h1,
    ST_SW_ON_DIS = 4'h2,
    ST_READY = 4'h3,
    ST_SWITCHED_ON = 4'h4,
    ST_OP_ENABLED = 4'h5,
    ST_QSTOP = 4'h6,
    ST_FAULT_REACT = 4'h7,
    ST_FAULT = 4'h8
  } dcwsm_state_t;

  typedef enum logic [1:0] {
    STOP_FAST = 2'h0,
    STOP_RAMP = 2'h1,
    STOP_FREEWHEEL = 2'h2,
    STOP_DC = 2'h3
  } dcwsm_stop_t;
endpackage : dcwsm_pkg

// [dcwsm_top.sv]
`timescale 1ns/100ps
module dcwsm_top #(
  parameter int CW_W = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rd_data_o,
  // Drive status from same-clock logic
  input wire logic init_done_i,
  input wire logic fault_active_i,
  input wire logic fault_reaction_done_i,
  input wire logic stop_done_i,
  // Terminal pins
  input wire logic fast_stop_pin_i,
  input wire logic freewheel_pin_i,
  // Drive controls
  output logic [3:0] state_o,
  output logic motor_power_o,
  output logic power_stage_req_o,
  output logic contactor_req_o,
  output logic ac_power_auth_o,
  output logic reverse_o,
  output logic halt_o,
  output logic [1:0] halt_stop_kind_select_o,
  output logic ramp_stop_o,
  output logic freewheel_o,
  output logic dc_brake_o
);
  if (CW_W != 16) begin : g_bad_width
    $error("dcwsm_top supports a 16-bit command word only");
  end

  localparam int CFG_W_L = dcwsm_pkg::CFG_W;
  logic rst_q1, rst_n, refused, freset_prev, freset_pend, qs_running;
  logic [1:0] fast_sync, free_sync;
  logic [15:0] cmd, assign_map;
  logic [CFG_W_L-1:0] cfg;
  dcwsm_pkg::dcwsm_state_t state, next_state;

  // Reset release through two flip-flops
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // Pins cross into the clock domain; only the second stage is read by logic
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      fast_sync <= 2'h0;
      free_sync <= 2'h0;
    end else begin
      fast_sync <= {fast_sync[0], fast_stop_pin_i};
      free_sync <= {free_sync[0], freewheel_pin_i};
    end
  end

  // Bit carrying a function code; code 0 or out of range reads as inactive
  function automatic logic assigned_bit(input logic [15:0] w, input logic [2:0] code);
    logic r;
    r = 1'b0;
    if (code >= dcwsm_pkg::ASG_C311 && code <= dcwsm_pkg::ASG_C315) begin
      r = w[dcwsm_pkg::B_ASSIGN_BASE + int'(code)];
    end
    return r;
  endfunction : assigned_bit

  // Command decode looks only at the significant bits of each command
  logic cmd_dis_volt, cmd_qstop, cmd_shutdown, cmd_switch_on, cmd_enable_op;
  logic fast_req, free_req, cfg_wr, cfg_ok, cfg_return;
  assign cmd_dis_volt = !cmd[dcwsm_pkg::B_EN_VOLT];
  assign cmd_qstop = cmd[dcwsm_pkg::B_EN_VOLT] && !cmd[dcwsm_pkg::B_QSTOP];
  assign cmd_shutdown = cmd[2:0] == 3'h6;
  assign cmd_switch_on = cmd[2:0] == 3'h7 && !cmd[dcwsm_pkg::B_EN_OP];
  assign cmd_enable_op = cmd[3:0] == 4'hF;
  assign fast_req = fast_sync[1] ||
    assigned_bit(cmd, assign_map[dcwsm_pkg::ASG_FAST +: 3]);
  assign free_req = free_sync[1] ||
    assigned_bit(cmd, assign_map[dcwsm_pkg::ASG_FREEWHEEL +: 3]);
  assign cfg_wr = wr_i && (addr_i == dcwsm_pkg::ADDR_CFG || addr_i == dcwsm_pkg::ADDR_ASSIGN);
  assign cfg_ok = state != dcwsm_pkg::ST_OP_ENABLED && state != dcwsm_pkg::ST_QSTOP &&
    state != dcwsm_pkg::ST_FAULT_REACT;
  assign cfg_return = cfg_wr && state == dcwsm_pkg::ST_SWITCHED_ON;

  // Register writes; config is refused while the motor may be running
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cmd <= dcwsm_pkg::CMD_RST;
      cfg <= dcwsm_pkg::CFG_RST;
      assign_map <= dcwsm_pkg::ASSIGN_RST;
      refused <= 1'b0;
    end else if (wr_i) begin
      if (addr_i == dcwsm_pkg::ADDR_CMD) begin
        cmd <= wr_data_i;
      end else if (addr_i == dcwsm_pkg::ADDR_CFG) begin
        refused <= !cfg_ok;
        if (cfg_ok) begin
          cfg <= wr_data_i[CFG_W_L-1:0];
        end
      end else if (addr_i == dcwsm_pkg::ADDR_ASSIGN) begin
        refused <= !cfg_ok;
        if (cfg_ok) begin
          assign_map <= wr_data_i & 16'h7777;
        end
      end
    end
  end

  // Fault reset edge is held until the cause of the error has gone
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      freset_prev <= 1'b0;
      freset_pend <= 1'b0;
    end else begin
      freset_prev <= cmd[dcwsm_pkg::B_FRESET];
      if (state != dcwsm_pkg::ST_FAULT) begin
        freset_pend <= 1'b0;
      end else if (cmd[dcwsm_pkg::B_FRESET] && !freset_prev) begin
        freset_pend <= 1'b1;
      end
    end
  end

  // Operating state machine; unmatched patterns keep the state
  always_comb begin
    next_state = state;
    if (fault_active_i && state != dcwsm_pkg::ST_FAULT_REACT && state != dcwsm_pkg::ST_FAULT &&
        state != dcwsm_pkg::ST_NOT_READY) begin
      next_state = dcwsm_pkg::ST_FAULT_REACT;
    end else begin
      case (state)
        dcwsm_pkg::ST_NOT_READY: begin
          if (init_done_i) next_state = dcwsm_pkg::ST_SW_ON_DIS;
        end
        dcwsm_pkg::ST_SW_ON_DIS: begin
          if (cmd_shutdown && !free_req) next_state = dcwsm_pkg::ST_READY;
        end
        dcwsm_pkg::ST_READY: begin
          if (cmd_dis_volt || cmd_qstop || free_req) next_state = dcwsm_pkg::ST_SW_ON_DIS;
          else if (cmd_enable_op) next_state = dcwsm_pkg::ST_OP_ENABLED;
          else if (cmd_switch_on) next_state = dcwsm_pkg::ST_SWITCHED_ON;
        end
        dcwsm_pkg::ST_SWITCHED_ON: begin
          if (cmd_dis_volt || cmd_qstop || free_req || cfg_return) begin
            next_state = dcwsm_pkg::ST_SW_ON_DIS;
          end else if (cmd_shutdown) next_state = dcwsm_pkg::ST_READY;
          else if (cmd_enable_op && !fast_req) next_state = dcwsm_pkg::ST_OP_ENABLED;
        end
        dcwsm_pkg::ST_OP_ENABLED: begin
          if (cmd_dis_volt || free_req) next_state = dcwsm_pkg::ST_SW_ON_DIS;
          else if (cmd_qstop) next_state = dcwsm_pkg::ST_QSTOP;
          else if (cmd_shutdown) next_state = dcwsm_pkg::ST_READY;
          else if (fast_req) next_state = dcwsm_pkg::ST_SWITCHED_ON;
          else if (cmd_switch_on && (!cfg[dcwsm_pkg::CFG_DIS_OP_STOP] || stop_done_i)) begin
            next_state = dcwsm_pkg::ST_SWITCHED_ON;
          end
        end
        dcwsm_pkg::ST_QSTOP: begin
          if (cmd_dis_volt || free_req) next_state = dcwsm_pkg::ST_SW_ON_DIS;
          else if (cmd_shutdown) next_state = dcwsm_pkg::ST_READY;
          else if (stop_done_i && !cfg[dcwsm_pkg::CFG_QS_HOLD]) begin
            next_state = dcwsm_pkg::ST_SW_ON_DIS;
          end
        end
        dcwsm_pkg::ST_FAULT_REACT: begin
          if (fault_reaction_done_i) next_state = dcwsm_pkg::ST_FAULT;
        end
        dcwsm_pkg::ST_FAULT: begin
          if (freset_pend && !fault_active_i) next_state = dcwsm_pkg::ST_SW_ON_DIS;
          else if (cmd_shutdown && !fault_active_i) next_state = dcwsm_pkg::ST_READY;
        end
        default: next_state = dcwsm_pkg::ST_NOT_READY;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= dcwsm_pkg::ST_NOT_READY;
    end else begin
      state <= next_state;
    end
  end

  // Quick stop of state 6 is in progress
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      qs_running <= 1'b0;
    end else begin
      if (next_state != dcwsm_pkg::ST_QSTOP) qs_running <= 1'b0;
      else if (state != dcwsm_pkg::ST_QSTOP) qs_running <= 1'b1;
      else if (stop_done_i) qs_running <= 1'b0;
    end
  end

  // Drive controls, all registered
  logic halt_now, next_motor, next_stage;
  assign halt_now = next_state == dcwsm_pkg::ST_OP_ENABLED && cmd[dcwsm_pkg::B_HALT];
  always_comb begin
    next_motor = 1'b0;
    next_stage = 1'b0;
    case (next_state)
      dcwsm_pkg::ST_SWITCHED_ON: next_stage = 1'b1;
      dcwsm_pkg::ST_OP_ENABLED: begin
        next_stage = 1'b1;
        next_motor = !halt_now;
      end
      dcwsm_pkg::ST_QSTOP: begin
        next_stage = 1'b1;
        next_motor = state != dcwsm_pkg::ST_QSTOP || (qs_running && !stop_done_i);
      end
      dcwsm_pkg::ST_FAULT_REACT: begin
        next_stage = cfg[dcwsm_pkg::CFG_ERR_STAGE];
        next_motor = cfg[dcwsm_pkg::CFG_ERR_POWER];
      end
      default: next_motor = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_o <= 4'h1;
      motor_power_o <= 1'b0;
      power_stage_req_o <= 1'b0;
      contactor_req_o <= 1'b0;
      ac_power_auth_o <= 1'b0;
      reverse_o <= 1'b0;
      halt_o <= 1'b0;
      halt_stop_kind_select_o <= 2'h0;
      ramp_stop_o <= 1'b0;
      freewheel_o <= 1'b0;
      dc_brake_o <= 1'b0;
    end else begin
      state_o <= next_state;
      motor_power_o <= next_motor;
      power_stage_req_o <= next_stage;
      contactor_req_o <= cmd[dcwsm_pkg::B_SWITCH_ON];
      ac_power_auth_o <= cmd[dcwsm_pkg::B_EN_VOLT];
      reverse_o <= assigned_bit(cmd, assign_map[dcwsm_pkg::ASG_REVERSE +: 3]);
      halt_o <= halt_now;
      halt_stop_kind_select_o <= cfg[dcwsm_pkg::CFG_STOP_KIND +: 2];
      // Taken from the next state so the ramp flag drops on the same edge as state 4 shows
      ramp_stop_o <= next_state == dcwsm_pkg::ST_OP_ENABLED && cmd_switch_on &&
        cfg[dcwsm_pkg::CFG_DIS_OP_STOP];
      // Freewheel on a clear CFG_DIS_OP_STOP bit bypasses the ramp entirely
      freewheel_o <= state == dcwsm_pkg::ST_OP_ENABLED && next_state == dcwsm_pkg::ST_SWITCHED_ON &&
        !cfg[dcwsm_pkg::CFG_DIS_OP_STOP];
      dc_brake_o <= next_state == dcwsm_pkg::ST_OP_ENABLED &&
        assigned_bit(cmd, assign_map[dcwsm_pkg::ASG_DC +: 3]);
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_o <= 16'h0000;
    end else if (!rd_i) begin
      rd_data_o <= 16'h0000;
    end else if (addr_i == dcwsm_pkg::ADDR_CMD) begin
      rd_data_o <= cmd;
    end else if (addr_i == dcwsm_pkg::ADDR_CFG) begin
      rd_data_o <= {{(16 - CFG_W_L){1'b0}}, cfg};
    end else if (addr_i == dcwsm_pkg::ADDR_ASSIGN) begin
      rd_data_o <= assign_map;
    end else if (addr_i == dcwsm_pkg::ADDR_STATUS) begin
      rd_data_o <= {8'h00, halt_o, power_stage_req_o, motor_power_o, refused, state};
    end else begin
      rd_data_o <= 16'h0000;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  sequence s_fault_seen;
    state == dcwsm_pkg::ST_FAULT && freset_pend;
  endsequence
  sequence s_cause_gone;
    !fault_active_i;
  endsequence

  chk_shutdown_ready: assert property (
    (state == dcwsm_pkg::ST_SW_ON_DIS && cmd[2:0] == 3'h6 && !fault_active_i && !free_req)
      |=> state == dcwsm_pkg::ST_READY)
    else $error("shutdown did not reach ready");
  chk_enable_op: assert property (
    (state == dcwsm_pkg::ST_SWITCHED_ON && cmd[3:0] == 4'hF && !fault_active_i && !free_req &&
      !fast_req && !cfg_return) |=> state == dcwsm_pkg::ST_OP_ENABLED)
    else $error("enable operation ignored");
  chk_dis_volt: assert property (
    (!cmd[1] && !fault_active_i && state inside {dcwsm_pkg::ST_READY, dcwsm_pkg::ST_SWITCHED_ON,
      dcwsm_pkg::ST_OP_ENABLED, dcwsm_pkg::ST_QSTOP}) |=> state == dcwsm_pkg::ST_SW_ON_DIS)
    else $error("disable voltage ignored");
  chk_quick_stop: assert property (
    (state == dcwsm_pkg::ST_OP_ENABLED && cmd[2:1] == 2'h1 && !fault_active_i && !free_req)
      |=> state == dcwsm_pkg::ST_QSTOP)
    else $error("quick stop ignored");
  chk_fault_reset: assert property (
    (s_fault_seen ##0 s_cause_gone) |=> state == dcwsm_pkg::ST_SW_ON_DIS)
    else $error("fault reset not applied");
  chk_halt_power: assert property (
    halt_o |-> !motor_power_o && state == dcwsm_pkg::ST_OP_ENABLED)
    else $error("power while halted");
  chk_motor_states: assert property (
    motor_power_o |-> state inside {dcwsm_pkg::ST_OP_ENABLED, dcwsm_pkg::ST_QSTOP,
      dcwsm_pkg::ST_FAULT_REACT})
    else $error("motor power in wrong state");
  chk_cfg_refused: assert property (
    (wr_i && addr_i == dcwsm_pkg::ADDR_CFG && state == dcwsm_pkg::ST_OP_ENABLED)
      |=> $stable(cfg) && refused)
    else $error("config accepted while running");
  chk_reverse_map: assert property (
    (assign_map[2:0] == 3'h1) |=> reverse_o == $past(cmd[11]))
    else $error("direction bit not followed");
  chk_init_exit: assert property (
    (state == dcwsm_pkg::ST_NOT_READY && init_done_i) |=> state == dcwsm_pkg::ST_SW_ON_DIS)
    else $error("init done not honoured");
endmodule : dcwsm_top

// [dcwsm_top_bench.sv]
`timescale 1ns/100ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("unexpected %s: expected %h seen %h", nm, e, g); end end
module dcwsm_top_bench;
  logic clk_i, nrst_i, wr_i, rd_i, init_done_i, fault_active_i, fault_reaction_done_i;
  logic stop_done_i, fast_stop_pin_i, freewheel_pin_i;
  logic [7:0] addr_i;
  logic [15:0] wr_data_i, rd_data_o, d;
  logic [3:0] state_o, s;
  logic motor_power_o, power_stage_req_o, contactor_req_o, ac_power_auth_o, reverse_o;
  logic halt_o, ramp_stop_o, freewheel_o, dc_brake_o, fw_seen;
  logic [1:0] halt_stop_kind_select_o;
  int failures = 0;
  int samples_checked = 0;

  dcwsm_top dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .init_done_i(init_done_i),
    .fault_active_i(fault_active_i), .fault_reaction_done_i(fault_reaction_done_i),
    .stop_done_i(stop_done_i), .fast_stop_pin_i(fast_stop_pin_i),
    .freewheel_pin_i(freewheel_pin_i), .state_o(state_o), .motor_power_o(motor_power_o),
    .power_stage_req_o(power_stage_req_o), .contactor_req_o(contactor_req_o),
    .ac_power_auth_o(ac_power_auth_o), .reverse_o(reverse_o), .halt_o(halt_o),
    .halt_stop_kind_select_o(halt_stop_kind_select_o), .ramp_stop_o(ramp_stop_o),
    .freewheel_o(freewheel_o), .dc_brake_o(dc_brake_o));
  dcwsm_bus_master master_u (.clk_i(clk_i), .addr_o(addr_i), .wr_data_o(wr_data_i),
    .wr_o(wr_i), .rd_o(rd_i), .rd_data_i(rd_data_o));

  always #20 clk_i = ~clk_i;

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  // Bounded wait for a state; also notes any freewheel pulse on the way
  task automatic wait_state(input logic [3:0] e);
    fw_seen = 1'b0;
    for (int i = 0; i < 12; i++) begin
      @(posedge clk_i);
      #1;
      if (freewheel_o === 1'b1) fw_seen = 1'b1;
      if (state_o === e) break;
    end
    `CHK("state", e, state_o)
  endtask : wait_state

  task automatic cmd(input logic [15:0] w);
    master_u.write_reg(dcwsm_pkg::ADDR_CMD, w);
  endtask : cmd

  task automatic t_reset_values();
    `CHK("reset state", 4'h1, state_o)
    master_u.read_reg(dcwsm_pkg::ADDR_CMD, d);
    `CHK("cmd reset", 16'h0000, d)
    master_u.read_reg(dcwsm_pkg::ADDR_ASSIGN, d);
    `CHK("assign reset", 16'h0001, d)
    master_u.read_reg(8'h10, d);
    `CHK("unmapped read", 16'h0000, d)
    @(posedge clk_i);
    init_done_i <= 1'b1;
    wait_state(4'h2);
    $display("test reset_values done");
  endtask : t_reset_values

  task automatic t_enable_sequence();
    master_u.write_reg(dcwsm_pkg::ADDR_CFG, 16'h0002);
    master_u.read_reg(dcwsm_pkg::ADDR_CFG, d);
    `CHK("cfg in state 2", 16'h0002, d)
    cmd(16'h0006);
    wait_state(4'h3);
    cmd(16'h000F);
    wait_state(4'h5);
    `CHK("motor power", 1'b1, motor_power_o)
    `CHK("contactor", 1'b1, contactor_req_o)
    `CHK("ac auth", 1'b1, ac_power_auth_o)
    `CHK("stop kind", 2'h2, halt_stop_kind_select_o)
    cmd(16'h067F);
    repeat (4) @(posedge clk_i);
    `CHK("reserved bits", 4'h5, state_o)
    cmd(16'h0007);
    wait_state(4'h4);
    `CHK("freewheel pulse", 1'b1, fw_seen)
    `CHK("no power in 4", 1'b0, motor_power_o)
    cmd(16'h000F);
    wait_state(4'h5);
    $display("test enable_sequence done");
  endtask : t_enable_sequence

  task automatic t_halt_refuse();
    master_u.write_reg(dcwsm_pkg::ADDR_CFG, 16'h0001);
    master_u.read_reg(dcwsm_pkg::ADDR_CFG, d);
    `CHK("cfg refused", 16'h0002, d)
    master_u.read_reg(dcwsm_pkg::ADDR_STATUS, d);
    `CHK("refused flag", 1'b1, d[4])
    cmd(16'h010F);
    repeat (3) @(posedge clk_i);
    `CHK("halt", 1'b1, halt_o)
    `CHK("halt power", 1'b0, motor_power_o)
    master_u.read_state(s);
    `CHK("halt state", 4'h5, s)
    cmd(16'h080F);
    repeat (3) @(posedge clk_i);
    `CHK("halt off", 1'b0, halt_o)
    `CHK("reverse", 1'b1, reverse_o)
    $display("test halt_refuse done");
  endtask : t_halt_refuse

  task automatic t_quick_stop();
    cmd(16'h0002);
    wait_state(4'h6);
    `CHK("power in 6", 1'b1, motor_power_o)
    @(posedge clk_i);
    stop_done_i <= 1'b1;
    wait_state(4'h2);
    @(posedge clk_i);
    stop_done_i <= 1'b0;
    $display("test quick_stop done");
  endtask : t_quick_stop

  task automatic t_pins_assign();
    cmd(16'h0006);
    wait_state(4'h3);
    cmd(16'h000F);
    wait_state(4'h5);
    @(posedge clk_i);
    fast_stop_pin_i <= 1'b1;
    wait_state(4'h4);
    @(posedge clk_i);
    fast_stop_pin_i <= 1'b0;
    master_u.write_reg(dcwsm_pkg::ADDR_ASSIGN, 16'h0301);
    wait_state(4'h2);
    cmd(16'h0006);
    wait_state(4'h3);
    cmd(16'h000F);
    wait_state(4'h5);
    cmd(16'h200F);
    wait_state(4'h2);
    for (int k = 1; k <= 5; k++) begin
      master_u.write_reg(dcwsm_pkg::ADDR_ASSIGN, 16'(k));
      cmd(16'h0006 | (16'h0001 << (10 + k)));
      repeat (3) @(posedge clk_i);
      `CHK("assigned reverse", 1'b1, reverse_o)
    end
    $display("test pins_assign done");
  endtask : t_pins_assign

  task automatic t_fault();
    cmd(16'h000F);
    wait_state(4'h5);
    @(posedge clk_i);
    fault_active_i <= 1'b1;
    wait_state(4'h7);
    `CHK("power in 7", 1'b0, motor_power_o)
    `CHK("stage in 7", 1'b0, power_stage_req_o)
    @(posedge clk_i);
    fault_reaction_done_i <= 1'b1;
    wait_state(4'h8);
    cmd(16'h0080);
    repeat (4) @(posedge clk_i);
    `CHK("reset held off", 4'h8, state_o)
    @(posedge clk_i);
    fault_active_i <= 1'b0;
    wait_state(4'h2);
    $display("test fault done");
  endtask : t_fault

  // Ramp select, dc brake assignment and quick-stop hold
  task automatic t_ramp_hold();
    master_u.write_reg(dcwsm_pkg::ADDR_CFG, 16'h000F);
    master_u.write_reg(dcwsm_pkg::ADDR_ASSIGN, 16'h3000);
    cmd(16'h0006);
    wait_state(4'h3);
    `CHK("stop kind dc", 2'h3, halt_stop_kind_select_o)
    cmd(16'h200F);
    wait_state(4'h5);
    `CHK("dc brake", 1'b1, dc_brake_o)
    `CHK("stage in 5", 1'b1, power_stage_req_o)
    cmd(16'h0007);
    repeat (4) @(posedge clk_i);
    `CHK("ramp wait", 4'h5, state_o)
    `CHK("ramp stop", 1'b1, ramp_stop_o)
    `CHK("dc brake off", 1'b0, dc_brake_o)
    stop_done_i <= 1'b1;
    wait_state(4'h4);
    `CHK("no freewheel", 1'b0, fw_seen)
    `CHK("ramp end", 1'b0, ramp_stop_o)
    `CHK("stage in 4", 1'b1, power_stage_req_o)
    cmd(16'h000F);
    wait_state(4'h5);
    cmd(16'h0002);
    wait_state(4'h6);
    repeat (4) @(posedge clk_i);
    `CHK("hold in 6", 4'h6, state_o)
    `CHK("stopped in 6", 1'b0, motor_power_o)
    cmd(16'h0000);
    wait_state(4'h2);
    @(posedge clk_i);
    stop_done_i <= 1'b0;
    $display("test ramp_hold done");
  endtask : t_ramp_hold

  initial begin
    clk_i = 1'b0;
    nrst_i = 1'b0;
    {init_done_i, fault_active_i, fault_reaction_done_i, stop_done_i} = 4'h0;
    {fast_stop_pin_i, freewheel_pin_i} = 2'h0;
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    t_reset_values();
    t_enable_sequence();
    t_halt_refuse();
    t_quick_stop();
    t_pins_assign();
    t_fault();
    t_ramp_hold();
    finish_test();
  end

  // Tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    failures++;
    finish_test();
  end
endmodule : dcwsm_top_bench
